/* hdl/lctp_top.sv */
// Display clock selection, frame timing, alternating drive and power control settings.
module lctp_top
  import lctp_pkg::*;
#(
  parameter int DUTY = 17,
  parameter logic [15:0] OSC_DIV = OSC_DIV_DEFAULT
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Device pins.
  input wire logic reset_pin_n,
  input wire logic display_clock_pin,
  input wire logic pixel_bit,
  // AXI4-Lite write address.
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  // AXI4-Lite write data.
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // AXI4-Lite write response.
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read address.
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  // AXI4-Lite read data.
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Power circuit controls.
  output lctp_power_t power_en,
  output logic [2:0] ratio_code,
  output logic divider_external,
  output logic [4:0] volume_offset,
  output logic power_save,
  // Timing and drive levels.
  output lctp_timing_t timing,
  output logic [2:0] segment_output,
  output logic [2:0] common_selected,
  output logic [2:0] common_unselected
);

  localparam logic [5:0] INT_LIMIT = lctp_int_tpl(DUTY) - 6'h01;
  localparam logic [5:0] EXT_LIMIT = EXT_TPL - 6'h01;
  localparam logic [5:0] LINE_LIMIT = 6'(DUTY - 1);
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  logic aw_held;
  logic w_held;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_fire;
  logic wr_byte;
  logic soft_rst;
  logic do_reset;
  logic [2:0] power;
  logic [2:0] ratio;
  logic [4:0] volume;
  logic inv_en;
  logic [5:0] inv_k;
  logic pin_q;
  logic [11:0] ext_cnt;
  lctp_src_t clk_src;
  logic [15:0] osc_cnt;
  logic disp_tick;
  logic [5:0] tick_limit;
  logic [5:0] tick_cnt;
  logic tick_wrap;
  logic [5:0] line_cnt;
  logic line_wrap;
  logic [5:0] inv_cnt;
  logic inv_wrap;
  logic alt;
  logic drive_off;
  logic [31:0] rd_mux;
  logic rd_ok;
  logic wr_ok;

  // Write channel: address and data are taken in either order.
  assign wr_fire = aw_held && w_held;
  assign wr_byte = wr_fire && wr_strb[0];
  assign wr_ok = (wr_addr == REG_CMD) || (wr_addr == REG_CTRL) || (wr_addr == REG_INV)
    || (wr_addr == REG_POWER) || (wr_addr == REG_RATIO) || (wr_addr == REG_VOLUME)
    || (wr_addr == REG_STATUS);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      wr_addr <= 8'h00;
      wr_data <= 32'h00000000;
      wr_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        s_axi_awready <= 1'b0;
        wr_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        s_axi_wready <= 1'b0;
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Read channel: the answer follows the address by one cycle.
  always_comb begin
    rd_mux = 32'h00000000;
    rd_ok = 1'b1;
    if (s_axi_araddr == REG_CMD) begin
      rd_mux = 32'h00000000;
    end else if (s_axi_araddr == REG_CTRL) begin
      rd_mux[CTRL_PSAVE_BIT] = power_save;
    end else if (s_axi_araddr == REG_INV) begin
      rd_mux[5:0] = inv_k;
      rd_mux[INV_EN_BIT] = inv_en;
    end else if (s_axi_araddr == REG_POWER) begin
      rd_mux[2:0] = power;
    end else if (s_axi_araddr == REG_RATIO) begin
      rd_mux[2:0] = ratio;
    end else if (s_axi_araddr == REG_VOLUME) begin
      rd_mux[4:0] = volume;
    end else if (s_axi_araddr == REG_STATUS) begin
      rd_mux[5:0] = line_cnt;
      rd_mux[ST_ALT_BIT] = alt;
      rd_mux[ST_PSAVE_BIT] = power_save;
      rd_mux[ST_SRC_LSB +: 3] = clk_src;
      rd_mux[ST_EXTDIV_BIT] = divider_external;
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Reset command and control bit give a one-cycle internal reset, like the pin.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      soft_rst <= 1'b0;
    end else begin
      soft_rst <= wr_byte && (((wr_addr == REG_CMD) && (wr_data[7:0] == CMD_RESET))
        || ((wr_addr == REG_CTRL) && wr_data[CTRL_RESET_BIT]));
    end
  end

  assign do_reset = !reset_pin_n || soft_rst;

  // Settings written through command bytes and the control registers.
  always_ff @(posedge aclk) begin
    if (!aresetn || do_reset) begin
      power_save <= 1'b1;
      power <= POWER_RST;
      ratio <= RATIO_RST;
      volume <= VOLUME_RST;
      inv_en <= 1'b0;
      inv_k <= INV_K_RST;
    end else if (wr_byte) begin
      if (wr_addr == REG_CMD) begin
        if ((wr_data[7:0] & CMD_VOL_MASK) == CMD_VOL_VAL) begin
          volume <= wr_data[4:0];
        end else if ((wr_data[7:0] & CMD_GRP_MASK) == CMD_RATIO_VAL) begin
          ratio <= wr_data[2:0];
        end else if ((wr_data[7:0] & CMD_GRP_MASK) == CMD_POWER_VAL) begin
          power <= wr_data[2:0];
        end
      end else if (wr_addr == REG_CTRL) begin
        power_save <= wr_data[CTRL_PSAVE_BIT];
      end else if (wr_addr == REG_INV) begin
        inv_k <= wr_data[5:0];
        inv_en <= wr_data[INV_EN_BIT];
      end
    end
  end

  // Power circuit outputs; power save holds every circuit off.
  // Illegal power combinations are passed through unchanged; software must avoid them.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      power_en <= '0;
      ratio_code <= RATIO_RST;
      divider_external <= 1'b0;
      volume_offset <= VOLUME_MAX - VOLUME_RST;
    end else begin
      power_en.booster <= power[2] && !power_save;
      power_en.regulator <= power[1] && !power_save;
      power_en.follower <= power[0] && !power_save;
      ratio_code <= ratio;
      divider_external <= (ratio == RATIO_EXT);
      volume_offset <= VOLUME_MAX - volume;
    end
  end

  // Clock source: a rising pin edge marks an external clock for a while.
  // A steady high pin only reads as internal after the timeout has run out.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_q <= 1'b0;
      ext_cnt <= 12'h000;
      clk_src <= SRC_OFF;
    end else begin
      pin_q <= display_clock_pin;
      if (display_clock_pin && !pin_q) begin
        ext_cnt <= EXT_TIMEOUT;
      end else if (ext_cnt != 12'h000) begin
        ext_cnt <= ext_cnt - 12'h001;
      end
      if (power_save) begin
        clk_src <= SRC_OFF;
      end else if (ext_cnt != 12'h000) begin
        clk_src <= SRC_EXT;
      end else if (display_clock_pin) begin
        clk_src <= SRC_INT;
      end else begin
        clk_src <= SRC_OFF;
      end
    end
  end

  // Display clock ticks: oscillator model or external pin edges.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_cnt <= 16'h0000;
      disp_tick <= 1'b0;
    end else begin
      case (clk_src)
        SRC_INT: begin
          disp_tick <= (osc_cnt == OSC_DIV - 16'h0001);
          osc_cnt <= (osc_cnt == OSC_DIV - 16'h0001) ? 16'h0000 : osc_cnt + 16'h0001;
        end
        SRC_EXT: begin
          disp_tick <= display_clock_pin && !pin_q;
          osc_cnt <= 16'h0000;
        end
        default: begin
          disp_tick <= 1'b0;
          osc_cnt <= 16'h0000;
        end
      endcase
    end
  end

  // Ticks per line depend on the duty and on the source.
  assign tick_limit = (clk_src == SRC_EXT) ? EXT_LIMIT : INT_LIMIT;

  lctp_counter #(.W(6)) u_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .clr(clk_src == SRC_OFF),
    .inc(disp_tick),
    .limit(tick_limit),
    .count(tick_cnt),
    .wrap(tick_wrap)
  );

  lctp_counter #(.W(6)) u_line (
    .aclk(aclk),
    .aresetn(aresetn),
    .clr(clk_src == SRC_OFF),
    .inc(tick_wrap),
    .limit(LINE_LIMIT),
    .count(line_cnt),
    .wrap(line_wrap)
  );

  lctp_counter #(.W(6)) u_inv (
    .aclk(aclk),
    .aresetn(aresetn),
    .clr(!inv_en),
    .inc(tick_wrap && inv_en),
    .limit(inv_k),
    .count(inv_cnt),
    .wrap(inv_wrap)
  );

  // Alternating signal: per frame, or every k+1 lines when inversion is on.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      alt <= 1'b0;
    end else if (inv_en) begin
      if (inv_wrap) begin
        alt <= !alt;
      end
    end else if (line_wrap) begin
      alt <= !alt;
    end
  end

  // Line latch and frame strobes come straight from the dividers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timing <= '0;
    end else begin
      timing.line_latch <= tick_wrap;
      timing.frame_start <= line_wrap;
      timing.alt <= alt;
      timing.line <= line_cnt;
    end
  end

  // Drive levels; all outputs sit at the ground level while the clock is off.
  assign drive_off = power_save || (clk_src == SRC_OFF);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      segment_output <= LV_VSS;
      common_selected <= LV_VSS;
      common_unselected <= LV_VSS;
    end else if (drive_off) begin
      segment_output <= LV_VSS;
      common_selected <= LV_VSS;
      common_unselected <= LV_VSS;
    end else begin
      segment_output <= pixel_bit ? (alt ? LV_VSS : LV_V0) : (alt ? LV_V2 : LV_V3);
      common_selected <= alt ? LV_V0 : LV_VSS;
      common_unselected <= alt ? LV_V4 : LV_V1;
    end
  end

  AST_INT_NEEDS_PIN: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_src == SRC_INT |-> $past(display_clock_pin) && !$past(power_save))
    else $error("Internal source without high pin or while saving power.");

  AST_LOW_PIN_STOPS: assert property (@(posedge aclk) disable iff (!aresetn)
    (!display_clock_pin && ext_cnt == 12'h000) [*2] |=> !disp_tick && clk_src != SRC_INT)
    else $error("Display clock still running with the pin held low.");

  AST_LINE_DIVIDE: assert property (@(posedge aclk) disable iff (!aresetn)
    tick_wrap |-> tick_cnt == ((clk_src == SRC_EXT) ? EXT_LIMIT : INT_LIMIT))
    else $error("Line ended after the wrong number of display clocks.");

  AST_FRAME_LINES: assert property (@(posedge aclk) disable iff (!aresetn)
    line_wrap |-> line_cnt == LINE_LIMIT ##1 timing.frame_start)
    else $error("Frame length differs from the duty.");

  AST_DUAL_FRAME: assert property (@(posedge aclk) disable iff (!aresetn)
    !inv_en && line_wrap |=> alt != $past(alt))
    else $error("Alternating signal missed its frame toggle.");

  AST_NLINE_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    inv_en && !inv_wrap |=> $stable(alt))
    else $error("Alternating signal toggled between inversion points.");

  AST_POWER_BITS: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 power_en == ({3{!$past(power_save)}} & $past(power)))
    else $error("Power enables do not follow the power bits.");

  AST_VOLUME_OFFSET: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 volume_offset == VOLUME_MAX - $past(volume))
    else $error("Volume offset is not 31 minus the contrast code.");

  AST_EXT_DIVIDER: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 divider_external == ($past(ratio) == RATIO_EXT))
    else $error("External divider flag wrong for the ratio code.");

  AST_VOLUME_CMD: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_byte && !do_reset && wr_addr == REG_CMD && wr_data[7:5] == 3'h4
    |=> volume == $past(wr_data[4:0]))
    else $error("Contrast command did not load the low five bits.");

  AST_RESET_STATE: assert property (@(posedge aclk) disable iff (!aresetn)
    do_reset |=> power_save && power == POWER_RST && ratio == RATIO_RST
      && volume == VOLUME_RST ##1 clk_src == SRC_OFF)
    else $error("Reset did not restore power save and default settings.");

endmodule

/* common/lctp_pkg.sv */
// Shared constants, types and command encodings for the LCD clock, timing and power block.
package lctp_pkg;

  // Register byte offsets on the AXI4-Lite bus.
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_CTRL = 8'h04;
  localparam logic [7:0] REG_INV = 8'h08;
  localparam logic [7:0] REG_POWER = 8'h0c;
  localparam logic [7:0] REG_RATIO = 8'h10;
  localparam logic [7:0] REG_VOLUME = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;

  // Field positions.
  localparam int CTRL_PSAVE_BIT = 0;
  localparam int CTRL_RESET_BIT = 1;
  localparam int INV_EN_BIT = 7;
  localparam int ST_ALT_BIT = 8;
  localparam int ST_PSAVE_BIT = 9;
  localparam int ST_SRC_LSB = 10;
  localparam int ST_EXTDIV_BIT = 13;

  // Command byte patterns.
  localparam logic [7:0] CMD_VOL_MASK = 8'he0;
  localparam logic [7:0] CMD_VOL_VAL = 8'h80;
  localparam logic [7:0] CMD_GRP_MASK = 8'hf8;
  localparam logic [7:0] CMD_RATIO_VAL = 8'h20;
  localparam logic [7:0] CMD_POWER_VAL = 8'h28;
  localparam logic [7:0] CMD_RESET = 8'he2;

  // Values after reset and special codes.
  localparam logic [2:0] POWER_RST = 3'h0;
  localparam logic [2:0] RATIO_RST = 3'h0;
  localparam logic [2:0] RATIO_EXT = 3'h7;
  localparam logic [4:0] VOLUME_RST = 5'h10;
  localparam logic [4:0] VOLUME_MAX = 5'h1f;
  localparam logic [5:0] INV_K_RST = 6'h00;

  // Cycle counts.
  localparam logic [15:0] OSC_DIV_DEFAULT = 16'h03e8;
  localparam logic [11:0] EXT_TIMEOUT = 12'h800;
  localparam logic [5:0] EXT_TPL = 6'h10;
  localparam logic [5:0] INT_TPL_9 = 6'h20;
  localparam logic [5:0] INT_TPL_17 = 6'h10;
  localparam logic [5:0] INT_TPL_33 = 6'h08;

  // Display clock source, one-hot.
  typedef enum logic [2:0] {
    SRC_OFF = 3'b001,
    SRC_INT = 3'b010,
    SRC_EXT = 3'b100
  } lctp_src_t;

  // Drive level codes for segment and common outputs.
  localparam logic [2:0] LV_VSS = 3'h0;
  localparam logic [2:0] LV_V4 = 3'h1;
  localparam logic [2:0] LV_V3 = 3'h2;
  localparam logic [2:0] LV_V2 = 3'h3;
  localparam logic [2:0] LV_V1 = 3'h4;
  localparam logic [2:0] LV_V0 = 3'h5;

  typedef struct packed {
    logic booster;
    logic regulator;
    logic follower;
  } lctp_power_t;

  typedef struct packed {
    logic line_latch;
    logic frame_start;
    logic alt;
    logic [5:0] line;
  } lctp_timing_t;

  // Display clock ticks per line with the internal source, by duty.
  function automatic logic [5:0] lctp_int_tpl(input int duty);
    case (duty)
      9: lctp_int_tpl = INT_TPL_9;
      33: lctp_int_tpl = INT_TPL_33;
      default: lctp_int_tpl = INT_TPL_17;
    endcase
  endfunction

endpackage

/* hdl/lctp_counter.sv */
// Wrapping counter with a programmable limit, used for the timing dividers.
module lctp_counter
  import lctp_pkg::*;
#(
  parameter int W = 6
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Control.
  input wire logic clr,
  input wire logic inc,
  input wire logic [W-1:0] limit,
  // Status.
  output logic [W-1:0] count,
  output logic wrap
);

  // Greater-or-equal so that a limit lowered mid-count still wraps at once.
  assign wrap = inc && (count >= limit);

  always_ff @(posedge aclk) begin
    if (!aresetn || clr) begin
      count <= '0;
    end else if (wrap) begin
      count <= '0;
    end else if (inc) begin
      count <= count + {{(W-1){1'b0}}, 1'b1};
    end
  end

endmodule

/* sim/lctp_host.sv */
// Host processor model that issues register accesses over AXI4-Lite.
module lctp_host
  import lctp_pkg::*;
(
  // Clock.
  input wire logic aclk,
  // Write channels.
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [7:0] s_axi_awaddr,
  output logic [2:0] s_axi_awprot,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  // Read channels.
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  output logic [7:0] s_axi_araddr,
  output logic [2:0] s_axi_arprot,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    s_axi_awvalid = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_awprot = 3'h0;
    s_axi_wvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_arprot = 3'h0;
    s_axi_rready = 1'b0;
  end

  // Local flags track the channels, since the outputs only change after the edge.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw;
    logic w;
    @(posedge aclk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_bready <= 1'b1;
    aw = 1'b1;
    w = 1'b1;
    while (aw || w) begin
      @(posedge aclk);
      if (aw && s_axi_awready) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (!s_axi_bvalid) @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge aclk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule

/* sim/lctp_top_tb.sv */
// Self-checking bench for the display clock, timing and power control block.
module lctp_top_tb
  import lctp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // A short oscillator divisor keeps frame periods to about a thousand cycles.
  localparam logic [15:0] DIV = 16'h0004;
  localparam int TPL = 16;
  localparam int EXT_P = 6;
  logic aclk, aresetn, reset_pin_n, display_clock_pin, pixel_bit, ext_run;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic divider_external, power_save;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot, ratio_code, segment_output, common_selected;
  logic [2:0] common_unselected;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, ext_ph;
  logic [4:0] volume_offset;
  lctp_power_t power_en;
  lctp_timing_t timing;
  int bad_count, comparisons;
  logic [7:0] vcodes [5] = '{8'h80, 8'h81, 8'h90, 8'h9f, 8'ha0};
  logic [2:0] pcodes [4] = '{3'h7, 3'h3, 3'h1, 3'h0};

  lctp_top #(.DUTY(17), .OSC_DIV(DIV)) DUT (
    .aclk, .aresetn, .reset_pin_n, .display_clock_pin, .pixel_bit,
    .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_awprot,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
    .power_en, .ratio_code, .divider_external, .volume_offset, .power_save,
    .timing, .segment_output, .common_selected, .common_unselected);

  lctp_host host (
    .aclk, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_awprot,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  // External display clock, toggled every third cycle while enabled.
  always @(posedge aclk) begin
    if (ext_run) begin
      ext_ph <= (ext_ph == 2'h2) ? 2'h0 : ext_ph + 2'h1;
      if (ext_ph == 2'h2) display_clock_pin <= ~display_clock_pin;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask

  // Cycles between two events: 0 line latch, 1 frame start, 2 alternation change.
  task automatic gap(input int sel, output int n);
    logic p;
    logic hit;
    int i;
    p = timing.alt;
    n = 0;
    i = 0;
    while (i < 2 && n < 5000) begin
      @(posedge aclk);
      #1;
      hit = (sel == 0) ? timing.line_latch : (sel == 1) ? timing.frame_start : (timing.alt !== p);
      if (i == 1) n++;
      if (hit === 1'b1) i++;
      p = timing.alt;
    end
  endtask

  task automatic t_reset;
    logic [31:0] d;
    logic [1:0] r;
    wait_cyc(1);
    check(power_save, 1, "power save after reset");
    check(power_en, 0, "power enables after reset");
    check(ratio_code, 0, "ratio after reset");
    check(volume_offset, 15, "volume offset after reset");
    host.rd(REG_STATUS, d, r);
    check(d[12:10], SRC_OFF, "source during power save");
    host.rd(8'hfc, d, r);
    check(r, 2'b10, "unmapped read response");
    host.wr(8'hfc, 32'h0);
    check(s_axi_bresp, 2'b10, "unmapped write response");
    $display("test reset done");
  endtask

  task automatic t_volume;
    logic [4:0] e;
    foreach (vcodes[i]) begin
      host.wr(REG_CMD, {24'h0, vcodes[i]});
      wait_cyc(2);
      e = (vcodes[i] < 8'ha0) ? 5'h1f - vcodes[i][4:0] : 5'h00;
      check(volume_offset, e, "volume offset");
    end
    $display("test volume done");
  endtask

  task automatic t_ratio;
    for (int r = 0; r < 8; r++) begin
      host.wr(REG_CMD, 32'h20 + r);
      wait_cyc(2);
      check(ratio_code, r[2:0], "ratio code");
      check(divider_external, r == 7, "external divider");
    end
    $display("test ratio done");
  endtask

  task automatic t_power;
    host.wr(REG_CTRL, 32'h0);
    wait_cyc(2);
    check(power_save, 0, "power save cleared");
    foreach (pcodes[i]) begin
      host.wr(REG_CMD, 32'h28 | pcodes[i]);
      wait_cyc(2);
      check(power_en, pcodes[i], "power enables");
    end
    $display("test power done");
  endtask

  task automatic t_internal;
    logic [31:0] d;
    logic [1:0] r;
    int n;
    @(posedge aclk);
    display_clock_pin <= 1'b1;
    wait_cyc(2100);
    host.rd(REG_STATUS, d, r);
    check(d[12:10], SRC_INT, "internal source");
    gap(0, n);
    check(n, DIV * TPL, "internal line period");
    gap(1, n);
    check(n, DIV * TPL * 17, "internal frame period");
    gap(2, n);
    check(n, DIV * TPL * 17, "alternation per frame");
    host.wr(REG_INV, 32'h84);
    gap(2, n);
    gap(2, n);
    check(n, DIV * TPL * 5, "alternation every five lines");
    host.wr(REG_INV, 32'h0);
    // Levels and the registered alternating signal come from the same edge, so they agree.
    @(posedge aclk);
    pixel_bit <= 1'b1;
    wait_cyc(2);
    check(segment_output, timing.alt ? LV_VSS : LV_V0, "lit segment level");
    check(common_selected, timing.alt ? LV_V0 : LV_VSS, "selected common level");
    check(common_unselected, timing.alt ? LV_V4 : LV_V1, "unselected common level");
    @(posedge aclk);
    pixel_bit <= 1'b0;
    wait_cyc(2);
    check(segment_output, timing.alt ? LV_V2 : LV_V3, "dark segment level");
    $display("test internal clock done");
  endtask

  task automatic t_external;
    logic [31:0] d;
    logic [31:0] q;
    logic [1:0] r;
    int n;
    @(posedge aclk);
    ext_run <= 1'b1;
    wait_cyc(100);
    host.rd(REG_STATUS, d, r);
    check(d[12:10], SRC_EXT, "external source");
    gap(0, n);
    check(n, EXT_P * TPL, "external line period");
    @(posedge aclk);
    ext_run <= 1'b0;
    @(posedge aclk);
    display_clock_pin <= 1'b0;
    wait_cyc(2100);
    host.rd(REG_STATUS, d, r);
    check(d[12:10], SRC_OFF, "clock off with pin low");
    wait_cyc(200);
    host.rd(REG_STATUS, q, r);
    check(q[5:0], d[5:0], "line stands still");
    $display("test external clock done");
  endtask

  task automatic t_reset_cmd;
    host.wr(REG_CMD, 32'h2f);
    host.wr(REG_CMD, 32'h95);
    wait_cyc(2);
    check(power_en, 3'h7, "all power on");
    host.wr(REG_CMD, {24'h0, CMD_RESET});
    wait_cyc(3);
    check(power_save, 1, "power save after command");
    check(power_en, 0, "power off after command");
    check(ratio_code, 0, "ratio after command");
    check(volume_offset, 15, "volume after command");
    check(segment_output, LV_VSS, "segment level after command");
    host.wr(REG_CMD, 32'h23);
    host.wr(REG_CMD, 32'h9f);
    @(posedge aclk);
    reset_pin_n <= 1'b0;
    repeat (2) @(posedge aclk);
    reset_pin_n <= 1'b1;
    wait_cyc(2);
    check(ratio_code, 0, "ratio after reset pin");
    check(volume_offset, 15, "volume after reset pin");
    $display("test reset command done");
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    bad_count++;
    test_done();
  end

  initial begin
    aresetn = 1'b0;
    reset_pin_n = 1'b1;
    display_clock_pin = 1'b0;
    pixel_bit = 1'b0;
    ext_run = 1'b0;
    ext_ph = 2'h0;
    bad_count = 0;
    comparisons = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_volume();
    t_ratio();
    t_power();
    t_internal();
    t_external();
    t_reset_cmd();
    test_done();
  end
endmodule
